// [common/imc_pkg.sv]
package imc_pkg;
	// register byte offsets
	localparam logic [7:0] A_PORT_STATUS    = 8'h00;
	localparam logic [7:0] A_PORT_CTL_ONE   = 8'h04;
	localparam logic [7:0] A_PORT_CTL_TWO   = 8'h08;
	localparam logic [7:0] A_SHIFT_BUFFER   = 8'h0c;
	localparam logic [7:0] A_SLAVE_RELOAD   = 8'h10;
	localparam logic [7:0] A_PERIPH_FLAGS_1 = 8'h14;
	localparam logic [7:0] A_PERIPH_ENABS_1 = 8'h18;
	localparam logic [7:0] A_PERIPH_FLAGS_2 = 8'h1c;
	localparam logic [7:0] A_PERIPH_ENABS_2 = 8'h20;
	// port_status fields
	localparam int B_STOP  = 4;
	localparam int B_START = 3;
	localparam int B_RW    = 2;
	localparam int B_BF    = 0;
	// port_control_one fields
	localparam int         B_WRITE_COLLISION_FLAG      = 7;
	localparam int         B_EN        = 5;
	localparam int         MODE_HI     = 3;
	localparam logic [3:0] MODE_MASTER = 4'h8;
	// port_control_two fields
	localparam int B_GCEN   = 7;
	localparam int B_ACK_RECEIVED_STATUS = 6;
	localparam int B_AKDT   = 5;
	localparam int B_ACK_SEND_REQUEST_BIT   = 4;
	localparam int B_RECEIVE_REQUEST_BIT   = 3;
	localparam int B_PEN    = 2;
	localparam int B_RESTART_REQUEST_BIT   = 1;
	localparam int B_SEN    = 0;
	// event and collision bit inside the flag and enable registers
	localparam int B_EVT = 3;
	localparam int B_BCL = 3;
	// sequencing constants
	localparam int         RELOAD_W  = 7;
	localparam logic [4:0] REQ_NONE  = 5'h00;
	localparam logic [3:0] LAST_DATA = 4'h7;
	localparam logic [3:0] ACK_BIT   = 4'h8;
	localparam logic [1:0] STEP_LOW  = 2'h0;
	localparam logic [1:0] STEP_HIGH = 2'h1;
	localparam logic [1:0] STEP_END  = 2'h2;
	localparam logic [6:0] BRG_ZERO  = 7'h00;
	localparam logic [6:0] RELOAD_RST = 7'h00;

	typedef enum logic [6:0] {
		S_IDLE   = 7'h01,
		S_START  = 7'h02,
		S_RSTART = 7'h04,
		S_TX     = 7'h08,
		S_RX     = 7'h10,
		S_ACK    = 7'h20,
		S_STOP   = 7'h40
	} imc_fsm_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} imc_line_t;

	typedef struct packed {
		imc_fsm_t    st;
		logic [1:0]  step;
		logic [3:0]  bitn;
		logic [6:0]  brg;
		logic [7:0]  shreg;
		imc_line_t   sy1;
		imc_line_t   sy2;
		imc_line_t   prev;
		imc_line_t   drv;
		logic        en;
		logic [3:0]  mode;
		logic        write_collision_flag;
		logic [7:0]  ctl2;
		logic [7:0]  buf_q;
		logic        bf;
		logic [6:0]  reload;
		logic        stop_seen;
		logic        start_seen;
		logic        evt_flag;
		logic        bcl_flag;
		logic        evt_en;
		logic        bcl_en;
		logic [31:0] rdata;
		logic        slverr;
	} imc_state_t;
endpackage

// [rtl/imc_master_port.sv]
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module imc_master_port (
	// clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// apb slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	// two-wire bus pins, open drain
	input  wire imc_pkg::imc_line_t line_i,
	output imc_pkg::imc_line_t      line_o,
	output imc_pkg::imc_line_t      line_oe_n,
	// port interrupt request
	output logic                    irq
);
	import imc_pkg::*;

	imc_state_t r;
	imc_state_t n;
	logic       master;
	logic       wr;
	logic       rd;
	logic       wr_ctl2;
	logic       wr_buf;
	logic       scl_hold;
	logic       tick;
	logic       start_det;
	logic       stop_det;
	logic       arb_lost;
	logic       evt_set;
	logic       bcl_set;
	logic       write_collision_flag_set;
	logic       fin;
	logic [4:0] req;
	logic [7:0] status_byte;
	logic [7:0] ctl1_byte;

	// lowest request bit wins, so one write never launches two operations
	function automatic logic [4:0] pick_req(input logic [4:0] w);
		logic [4:0] p;
		p = w & (~w + 5'h01);
		return p;
	endfunction

	// phases in which the line is expected high while we leave it released
	function automatic logic arb_phase(input imc_fsm_t s, input logic [1:0] p,
		input logic [3:0] b);
		logic ok;
		ok = 1'b0;
		case (s)
			S_START:  ok = 1'b1;
			S_RSTART: ok = (p == STEP_HIGH);
			S_TX:     ok = (p == STEP_HIGH) && (b != ACK_BIT);
			S_ACK:    ok = (p == STEP_HIGH);
			S_STOP:   ok = (p == STEP_END);
			default:  ok = 1'b0;
		endcase
		return ok;
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		return (a == A_PORT_STATUS) || (a == A_PORT_CTL_ONE) ||
			(a == A_PORT_CTL_TWO) || (a == A_SHIFT_BUFFER) ||
			(a == A_SLAVE_RELOAD) || (a == A_PERIPH_FLAGS_1) ||
			(a == A_PERIPH_ENABS_1) || (a == A_PERIPH_FLAGS_2) ||
			(a == A_PERIPH_ENABS_2);
	endfunction

	// decode of mode and enable; one write can set mode and enable together
	assign master   = r.en && (r.mode == MODE_MASTER);
	assign wr       = psel && penable && pwrite;
	assign rd       = psel && penable && !pwrite;
	assign wr_ctl2  = wr && (paddr == A_PORT_CTL_TWO);
	assign wr_buf   = wr && (paddr == A_SHIFT_BUFFER);
	// another device stretching the clock stalls the baud count
	assign scl_hold = !r.drv.scl && !r.sy2.scl && (r.st != S_START);
	assign tick     = (r.st != S_IDLE) && (r.brg == BRG_ZERO) && !scl_hold;
	// conditions seen on the synchronised lines
	assign start_det = r.prev.sda && !r.sy2.sda && r.sy2.scl && r.prev.scl;
	assign stop_det  = !r.prev.sda && r.sy2.sda && r.sy2.scl && r.prev.scl;
	// released data sampled low, or clock lost during a start
	assign arb_lost = tick && ((arb_phase(r.st, r.step, r.bitn) && !r.drv.sda &&
		!r.sy2.sda) || ((r.st == S_START) && !r.sy2.scl));

	assign status_byte = {3'h0, r.stop_seen, r.start_seen, r.st == S_TX, 1'b0, r.bf};
	assign ctl1_byte   = {r.write_collision_flag, 1'b0, r.en, 1'b0, r.mode};

	// next state of the whole port
	always_comb begin
		n = r;
		evt_set = 1'b0;
		bcl_set = 1'b0;
		write_collision_flag_set = 1'b0;
		fin = 1'b0;
		req = REQ_NONE;
		n.sy1 = line_i;
		n.sy2 = r.sy1;
		n.prev = r.sy2;
		// baud generator reloads whenever idle, stalled or expired
		if (r.st == S_IDLE || scl_hold || r.brg == BRG_ZERO)
			n.brg = r.reload;
		else
			n.brg = r.brg - 7'h01;
		// read data is captured in the setup phase for a zero-wait access
		if (psel && !penable) begin
			n.slverr = !is_mapped(paddr);
			n.rdata = 32'h0;
			if (paddr == A_PORT_STATUS)
				n.rdata[7:0] = status_byte;
			else if (paddr == A_PORT_CTL_ONE)
				n.rdata[7:0] = ctl1_byte;
			else if (paddr == A_PORT_CTL_TWO)
				n.rdata[7:0] = r.ctl2;
			else if (paddr == A_SHIFT_BUFFER)
				n.rdata[7:0] = r.buf_q;
			else if (paddr == A_SLAVE_RELOAD)
				n.rdata[RELOAD_W-1:0] = r.reload;
			else if (paddr == A_PERIPH_FLAGS_1)
				n.rdata[B_EVT] = r.evt_flag;
			else if (paddr == A_PERIPH_ENABS_1)
				n.rdata[B_EVT] = r.evt_en;
			else if (paddr == A_PERIPH_FLAGS_2)
				n.rdata[B_BCL] = r.bcl_flag;
			else if (paddr == A_PERIPH_ENABS_2)
				n.rdata[B_BCL] = r.bcl_en;
		end
		// register writes at the access phase
		if (wr) begin
			if (paddr == A_PORT_CTL_ONE) begin
				n.write_collision_flag = pwdata[B_WRITE_COLLISION_FLAG];
				n.en = pwdata[B_EN];
				n.mode = pwdata[MODE_HI:0];
			end else if (paddr == A_PORT_CTL_TWO) begin
				n.ctl2[B_GCEN] = pwdata[B_GCEN];
				n.ctl2[B_AKDT] = pwdata[B_AKDT];
				// request bits are dropped unless the port is in master mode and idle
				if (master && r.st == S_IDLE)
					req = pick_req(pwdata[B_ACK_SEND_REQUEST_BIT:B_SEN]);
			end else if (paddr == A_SHIFT_BUFFER) begin
				if (r.st != S_IDLE) begin
					write_collision_flag_set = 1'b1;
				end else begin
					n.buf_q = pwdata[7:0];
					n.shreg = pwdata[7:0];
				end
			end else if (paddr == A_SLAVE_RELOAD) begin
				n.reload = pwdata[RELOAD_W-1:0];
			end else if (paddr == A_PERIPH_FLAGS_1) begin
				n.evt_flag = pwdata[B_EVT];
			end else if (paddr == A_PERIPH_ENABS_1) begin
				n.evt_en = pwdata[B_EVT];
			end else if (paddr == A_PERIPH_FLAGS_2) begin
				n.bcl_flag = pwdata[B_BCL];
			end else if (paddr == A_PERIPH_ENABS_2) begin
				n.bcl_en = pwdata[B_BCL];
			end
		end
		if (rd && paddr == A_SHIFT_BUFFER)
			n.bf = 1'b0;
		// launch of an accepted operation
		if (req != REQ_NONE || (wr_buf && master && r.st == S_IDLE)) begin
			n.ctl2[B_ACK_SEND_REQUEST_BIT:B_SEN] = req;
			n.step = STEP_LOW;
			n.bitn = 4'h0;
		end
		if (req[B_SEN]) begin
			n.st = S_START;
		end else if (req[B_RESTART_REQUEST_BIT]) begin
			n.st = S_RSTART;
			n.drv.scl = 1'b1;
			n.drv.sda = 1'b0;
		end else if (req[B_PEN]) begin
			n.st = S_STOP;
			n.drv.scl = 1'b1;
			n.drv.sda = 1'b1;
		end else if (req[B_RECEIVE_REQUEST_BIT]) begin
			n.st = S_RX;
			n.drv.scl = 1'b1;
			n.drv.sda = 1'b0;
		end else if (req[B_ACK_SEND_REQUEST_BIT]) begin
			n.st = S_ACK;
			n.drv.scl = 1'b1;
			n.drv.sda = !pwdata[B_AKDT];
		end else if (wr_buf && master && r.st == S_IDLE) begin
			n.st = S_TX;
			n.bf = 1'b1;
			n.drv.scl = 1'b1;
			n.drv.sda = !pwdata[7];
		end
		// bit sequencer, one step per baud expiry; hardware owns both lines
		if (tick) begin
			case (r.st)
				S_START: begin
					if (r.step == STEP_LOW) begin
						n.drv.sda = 1'b1;
						n.step = STEP_HIGH;
					end else begin
						fin = 1'b1;
					end
				end
				S_RSTART: begin
					if (r.step == STEP_LOW) begin
						n.drv.scl = 1'b0;
						n.step = STEP_HIGH;
					end else if (r.step == STEP_HIGH) begin
						n.drv.sda = 1'b1;
						n.step = STEP_END;
					end else begin
						fin = 1'b1;
					end
				end
				S_STOP: begin
					if (r.step == STEP_LOW) begin
						n.drv.scl = 1'b0;
						n.step = STEP_HIGH;
					end else if (r.step == STEP_HIGH) begin
						n.drv.sda = 1'b0;
						n.step = STEP_END;
					end else begin
						fin = 1'b1;
					end
				end
				S_TX, S_RX, S_ACK: begin
					if (r.step == STEP_LOW) begin
						n.drv.scl = 1'b0;
						n.step = STEP_HIGH;
					end else begin
						// data changes with the clock edge; both lines switch on the same pclk edge, no hold
						n.drv.scl = 1'b1;
						n.step = STEP_LOW;
						n.bitn = r.bitn + 4'h1;
						if (r.st == S_TX) begin
							if (r.bitn == ACK_BIT) begin
								n.ctl2[B_ACK_RECEIVED_STATUS] = r.sy2.sda;
								n.bf = 1'b0;
								fin = 1'b1;
							end else begin
								n.shreg = {r.shreg[6:0], 1'b0};
								n.drv.sda = (r.bitn == LAST_DATA) ? 1'b0 : !r.shreg[6];
							end
						end else if (r.st == S_RX) begin
							n.shreg = {r.shreg[6:0], r.sy2.sda};
							if (r.bitn == LAST_DATA) begin
								n.buf_q = {r.shreg[6:0], r.sy2.sda};
								n.bf = 1'b1;
								fin = 1'b1;
							end
						end else begin
							n.drv.sda = 1'b0;
							fin = 1'b1;
						end
					end
				end
				default: begin
					fin = 1'b0;
				end
			endcase
		end
		// completion: request bit clears and the event flag rises
		if (fin) begin
			n.st = S_IDLE;
			n.ctl2[B_ACK_SEND_REQUEST_BIT:B_SEN] = REQ_NONE;
			n.step = STEP_LOW;
			n.bitn = 4'h0;
			evt_set = 1'b1;
		end
		// lost arbitration: give both lines up and return to idle
		if (arb_lost) begin
			n.st = S_IDLE;
			n.drv = '0;
			n.ctl2[B_ACK_SEND_REQUEST_BIT:B_SEN] = REQ_NONE;
			n.step = STEP_LOW;
			n.bitn = 4'h0;
			bcl_set = 1'b1;
		end
		// bus condition watch runs while the port is on
		if (r.en && start_det) begin
			n.start_seen = 1'b1;
			n.stop_seen = 1'b0;
			evt_set = 1'b1;
		end
		if (r.en && stop_det) begin
			n.stop_seen = 1'b1;
			n.start_seen = 1'b0;
			evt_set = 1'b1;
		end
		// leaving master mode releases the bus; disabling forgets bus state
		if (!master) begin
			n.st = S_IDLE;
			n.drv = '0;
			n.ctl2[B_ACK_SEND_REQUEST_BIT:B_SEN] = REQ_NONE;
		end
		if (!r.en) begin
			n.start_seen = 1'b0;
			n.stop_seen = 1'b0;
		end
		// hardware sets win over a software clear in the same cycle
		n.evt_flag = n.evt_flag | evt_set;
		n.bcl_flag = n.bcl_flag | bcl_set;
		n.write_collision_flag = n.write_collision_flag | write_collision_flag_set;
	end

	// single state register; reset also clears the seen bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.st <= S_IDLE;
			r.reload <= RELOAD_RST;
		end else begin
			r <= n;
		end
	end

	// outputs: pins only ever pull low
	assign line_o    = '0;
	assign line_oe_n = imc_line_t'(~r.drv);
	assign prdata    = r.rdata;
	assign pready    = 1'b1;
	assign pslverr   = r.slverr;
	assign irq       = (r.evt_flag && r.evt_en) || (r.bcl_flag && r.bcl_en);

	chk_evt_raise: assert property (@(posedge pclk) disable iff (!presetn)
		evt_set |=> r.evt_flag) else $error("event flag not raised");
	chk_seen_clear: assert property (@(posedge pclk) disable iff (!presetn)
		!r.en |=> !r.start_seen && !r.stop_seen) else $error("seen bits kept");
	chk_stop_free: assert property (@(posedge pclk) disable iff (!presetn)
		r.en && stop_det |=> r.stop_seen && !r.start_seen && r.evt_flag)
		else $error("stop not reported");
	chk_lines_free: assert property (@(posedge pclk) disable iff (!presetn)
		!master |=> line_oe_n.scl && line_oe_n.sda) else $error("lines held");
	chk_arb_loss: assert property (@(posedge pclk) disable iff (!presetn)
		arb_lost |=> r.bcl_flag && r.st == S_IDLE && !r.drv.scl)
		else $error("collision not handled");
	chk_start_take: assert property (@(posedge pclk) disable iff (!presetn)
		wr_ctl2 && master && r.st == S_IDLE && pwdata[B_SEN]
		|=> r.st == S_START && r.ctl2[B_SEN]) else $error("start not taken");
	chk_tx_begin: assert property (@(posedge pclk) disable iff (!presetn)
		wr_buf && master && r.st == S_IDLE |=> (r.st == S_TX && r.bf) [*2])
		else $error("transmit not begun");
	chk_no_queue: assert property (@(posedge pclk) disable iff (!presetn)
		wr_ctl2 && r.st != S_IDLE
		|=> (r.ctl2[B_ACK_SEND_REQUEST_BIT:B_SEN] & ~$past(r.ctl2[B_ACK_SEND_REQUEST_BIT:B_SEN])) == REQ_NONE)
		else $error("request queued");
	chk_write_collision_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
		wr_buf && r.st != S_IDLE |=> r.write_collision_flag && $stable(r.buf_q))
		else $error("busy buffer write taken");
	chk_brg_load: assert property (@(posedge pclk) disable iff (!presetn)
		r.st == S_IDLE |=> r.brg == $past(r.reload)) else $error("bad reload");
	chk_ack_store: assert property (@(posedge pclk) disable iff (!presetn)
		master && tick && r.st == S_TX && r.step == STEP_HIGH && r.bitn == ACK_BIT
		|=> r.ctl2[B_ACK_RECEIVED_STATUS] == $past(r.sy2.sda) && r.evt_flag && r.st == S_IDLE)
		else $error("ack not stored");
	chk_start_end: assert property (@(posedge pclk) disable iff (!presetn)
		master && tick && r.st == S_START && r.step == STEP_HIGH && !arb_lost
		|=> !r.ctl2[B_SEN] && r.drv.sda && r.st == S_IDLE)
		else $error("start not completed");
endmodule // imc_master_port

// [test/imc_slave_model.sv]
`timescale 1ns/1ps
// two-wire slave: acks bytes sent to it, answers a read address with tx_byte
module imc_slave_model (
	// bus lines, levels after the pull-up
	input  wire logic       scl,
	input  wire logic       sda,
	output logic            sda_oe_n,
	// data
	input  wire logic [7:0] tx_byte,
	output logic [7:0]      rx_byte
);
	logic [3:0] cnt;
	logic [7:0] sh;
	logic       adr;
	logic       rdm;
	// released until addressed
	initial begin
		sda_oe_n = 1'b1;
		cnt = 4'h0;
		adr = 1'b0;
		rdm = 1'b0;
		sh = 8'h00;
		rx_byte = 8'h00;
	end
	// start arms the address phase, stop drops out; both only while scl is high
	always @(sda) begin
		if (scl) begin
			cnt = 4'h0;
			adr = !sda;
			rdm = 1'b0;
			sda_oe_n = 1'b1;
		end
	end
	// sample msb first on the rising clock
	always @(posedge scl) begin
		sh = {sh[6:0], sda};
		cnt = cnt + 4'h1;
	end
	// change sda only while scl is low so no false start or stop is made
	always @(negedge scl) begin
		if (cnt == 4'h8) begin
			rx_byte = sh;
			sda_oe_n = !(adr || !rdm);
			if (adr) rdm = sh[0];
		end else if (cnt == 4'h9) begin
			cnt = 4'h0;
			adr = 1'b0;
			if (sh[0]) rdm = 1'b0; // not-ack from the master ends a read
			sda_oe_n = rdm ? tx_byte[7] : 1'b1;
		end else if (rdm && !adr && cnt < 4'h8) begin
			sda_oe_n = tx_byte[3'h7 - cnt[2:0]];
		end
	end
endmodule // imc_slave_model

// [test/test_imc_master_port.sv]
`timescale 1ns/1ps
module test_imc_master_port;
	import imc_pkg::*;
	typedef struct packed {
		logic        w;
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] q;
		logic        e;
	} imc_row_t;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	imc_line_t   line_i;
	imc_line_t   line_o;
	imc_line_t   line_oe_n;
	logic        irq;
	logic        steal_n;
	logic        sl_oe_n;
	logic [7:0]  sl_rx;
	logic [31:0] r;
	logic        e;
	int          num_errors;
	int          comparisons;
	int          cycles;
	// register cases: write or read, address, data, expected read, expected error
	imc_row_t rows [10] = '{
		'{1'b1, A_SLAVE_RELOAD, 32'hff, 32'h0, 1'b0},
		'{1'b0, A_SLAVE_RELOAD, 32'h0, 32'h7f, 1'b0},
		'{1'b1, A_SLAVE_RELOAD, 32'h03, 32'h0, 1'b0},
		'{1'b0, A_SLAVE_RELOAD, 32'h0, 32'h03, 1'b0},
		'{1'b1, A_PERIPH_ENABS_2, 32'h08, 32'h0, 1'b0},
		'{1'b0, A_PERIPH_ENABS_2, 32'h0, 32'h08, 1'b0},
		'{1'b1, 8'h24, 32'h5a, 32'h0, 1'b1},
		'{1'b0, 8'h24, 32'h0, 32'h0, 1'b1},
		'{1'b1, A_PORT_CTL_ONE, 32'h08, 32'h0, 1'b0},
		'{1'b0, A_PORT_CTL_ONE, 32'h0, 32'h08, 1'b0}};

	// wired-and of every puller, pull-up when all release
	assign line_i = {line_oe_n.scl, line_oe_n.sda & sl_oe_n & steal_n};

	imc_master_port i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .line_i(line_i), .line_o(line_o),
		.line_oe_n(line_oe_n), .irq(irq));
	imc_slave_model i_slave (
		.scl(line_i.scl), .sda(line_i.sda), .sda_oe_n(sl_oe_n),
		.tx_byte(8'h5a), .rx_byte(sl_rx));

	// 100 ns clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// hang guard, far above the several hundred cycles the run needs
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			num_errors++;
			close_out();
		end
	end

	task automatic cmp_reg(input string nm, input logic [31:0] x, input logic [31:0] g);
		comparisons++;
		if (g !== x) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic cmp_bit(input string nm, input logic x, input logic g);
		comparisons++;
		if (g !== x) begin
			num_errors++;
			$display("[ERR] %s expected %b seen %b", nm, x, g);
		end
	endtask
	// one apb transfer; holds the request until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// pready seen high ends this wait; if it never comes, only the bench's hang guard ends it
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        err;
		apb(1'b1, a, d, q, err);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic err;
		apb(1'b0, a, 32'h0, q, err);
	endtask
	// poll until no request bit and no transmit is left, bounded
	task automatic wait_done();
		logic [31:0] c;
		logic [31:0] s;
		int          n;
		c = 32'h1f;
		s = 32'h0;
		n = 0;
		while ((c[4:0] !== 5'h00 || s[B_RW] !== 1'b0) && n < 400) begin
			rd(A_PORT_CTL_TWO, c);
			rd(A_PORT_STATUS, s);
			n++;
		end
		cmp_bit("op finished", 1'b1, n < 400);
	endtask
	// start an operation, wait for it, check and clear the event flag
	task automatic op(input logic [7:0] a, input logic [31:0] d, input logic ei);
		logic [31:0] f;
		wr(a, d);
		wait_done();
		rd(A_PERIPH_FLAGS_1, f);
		cmp_bit("event", 1'b1, f[B_EVT]);
		cmp_bit("irq", ei, irq);
		wr(A_PERIPH_FLAGS_1, 32'h0);
	endtask
	task automatic close_out();
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		steal_n = 1'b1;
		num_errors = 0;
		comparisons = 0;
		cycles = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			apb(rows[i].w, rows[i].a, rows[i].d, r, e);
			if (!rows[i].w) cmp_reg("register", rows[i].q, r);
			cmp_bit("slverr", rows[i].e, e);
		end
		wr(A_PORT_CTL_ONE, 32'h28);
		// bus is free: both seen bits clear; try to queue a byte and a stop
		wr(A_PORT_CTL_TWO, 32'h01);
		wr(A_SHIFT_BUFFER, 32'h33);
		wr(A_PORT_CTL_TWO, 32'h04);
		wait_done();
		cmp_reg("start lines", 32'h2, {30'h0, line_oe_n});
		rd(A_PORT_CTL_TWO, r);
		cmp_reg("ctl2", 32'h0, r);
		rd(A_PORT_STATUS, r);
		cmp_reg("seen", 32'h1, {30'h0, r[4:3]});
		rd(A_PORT_CTL_ONE, r);
		cmp_bit("write_collision_flag", 1'b1, r[B_WRITE_COLLISION_FLAG]);
		wr(A_PORT_CTL_ONE, 32'h28);
		wr(A_PERIPH_FLAGS_1, 32'h0);
		rd(A_SHIFT_BUFFER, r);
		cmp_reg("buffer kept", 32'h0, r);
		// address with the read bit, then a byte in, not-ack, restart, stop
		op(A_SHIFT_BUFFER, 32'ha1, 1'b0);
		cmp_reg("slave got", 32'ha1, {24'h0, sl_rx});
		rd(A_PORT_CTL_TWO, r);
		cmp_bit("ack seen", 1'b0, r[B_ACK_RECEIVED_STATUS]);
		cmp_bit("scl held", 1'b0, line_oe_n.scl);
		op(A_PORT_CTL_TWO, 32'h08, 1'b0);
		rd(A_SHIFT_BUFFER, r);
		cmp_reg("rx byte", 32'h5a, r);
		op(A_PORT_CTL_TWO, 32'h30, 1'b0);
		op(A_PORT_CTL_TWO, 32'h02, 1'b0);
		rd(A_PORT_STATUS, r);
		cmp_reg("seen", 32'h1, {30'h0, r[4:3]});
		wr(A_PERIPH_ENABS_1, 32'h08);
		op(A_PORT_CTL_TWO, 32'h04, 1'b1);
		cmp_reg("stop lines", 32'h3, {30'h0, line_oe_n});
		rd(A_PORT_STATUS, r);
		cmp_reg("seen", 32'h2, {30'h0, r[4:3]});
		// another master holds sda low while a one is sent
		op(A_PORT_CTL_TWO, 32'h01, 1'b1);
		steal_n <= 1'b0;
		wr(A_SHIFT_BUFFER, 32'hff);
		wait_done();
		rd(A_PERIPH_FLAGS_2, r);
		cmp_bit("collision", 1'b1, r[B_BCL]);
		cmp_reg("lost lines", 32'h3, {30'h0, line_oe_n});
		cmp_bit("irq", 1'b1, irq);
		steal_n <= 1'b1;
		wr(A_PERIPH_FLAGS_2, 32'h0);
		// disabling the port drops both seen bits
		wr(A_PORT_CTL_ONE, 32'h08);
		rd(A_PORT_STATUS, r);
		cmp_reg("seen off", 32'h0, {30'h0, r[4:3]});
		// second reset in mid-run: every register back to zero
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a <= 32; a += 4) begin
			rd(8'(a), r);
			cmp_reg("reset value", 32'h0, r);
		end
		cmp_reg("reset lines", 32'h3, {30'h0, line_oe_n});
		cmp_reg("pin drive level", 32'h0, {30'h0, line_o});
		close_out();
	end
endmodule // test_imc_master_port
